// ---- core/cie_core.sv ----
`timescale 1ns/10ps
module cie_core #(
    parameter int ROM_BYTES = cie_pkg::ROM_BYTES_DEF,
    parameter int RAM_BYTES = cie_pkg::RAM_BYTES_DEF
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // register port
    input  wire logic [2:0]           regAddr,
    input  wire logic [31:0]          regWdata,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic      [31:0]          regRdata,
    // highest pending maskable request from the sources
    input  cie_pkg::cie_irq_t         irqReq,
    // software trap from the sequencer
    input  wire logic                 trapReq,
    input  wire logic [5:0]           trapNum,
    input  wire logic [19:0]          returnPc,
    // memory port, read data one cycle after the read strobe
    output logic      [19:0]          memAddr,
    output logic                      memWrite,
    output logic                      memRead,
    output logic      [15:0]          memWdata,
    input  wire logic [15:0]          memRdata,
    // to sequencer
    output logic                      irqAck,
    output logic      [6:0]           ackVector,
    output logic                      jumpValid,
    output logic      [19:0]          jumpPc,
    output logic                      entryBusy,
    output logic      [19:0]          activeSp,
    output cie_pkg::cie_region_t      memRegion
);
    cie_pkg::cie_state_t state_reg;
    cie_pkg::cie_state_t state_next;

    logic [15:0] flags_reg;
    logic [15:0] savedFlags_reg;
    logic [19:0] savedPc_reg;
    logic [19:0] handlerSp_reg;
    logic [19:0] userSp_reg;
    logic [19:0] vecBase_reg;
    logic [6:0]  vector_reg;
    logic        fixedVec_reg;
    logic [15:0] vecLow_reg;
    logic [19:0] memAddr_reg;
    logic [19:0] memAddr_next;
    logic        memWrite_reg;
    logic        memRead_reg;
    logic [15:0] memWdata_reg;
    logic [15:0] memWdata_next;
    logic        irqAck_reg;
    logic        jumpValid_reg;
    logic        fetchHi_reg;
    logic [19:0] jumpPc_reg;
    logic        stackFault_reg;
    logic        accFault_reg;
    logic [31:0] regRdata_reg;

    logic        enableFlag;
    logic        stackSel;
    logic [2:0]  cpuPriorityLevel;
    logic        hwTake;
    logic        trapTake;
    logic        takeAny;
    logic [19:0] vecEntry;
    logic [19:0] pushAddr;
    logic        swFlagsWr;

    assign enableFlag       = flags_reg[cie_pkg::FLG_ENABLE];
    assign stackSel         = flags_reg[cie_pkg::FLG_STACKSEL];
    assign cpuPriorityLevel = flags_reg[cie_pkg::FLG_PRIO_MSB:cie_pkg::FLG_PRIO_LSB];

    assign activeSp = stackSel ? userSp_reg : handlerSp_reg;

    // traps are instructions and ignore the enable flag and level
    assign trapTake = state_reg == cie_pkg::CIE_IDLE && trapReq;
    // vectors beyond the 69 supported are never taken
    assign hwTake   = state_reg == cie_pkg::CIE_IDLE && !trapReq && irqReq.valid
                      && enableFlag
                      && irqReq.prio > cpuPriorityLevel
                      && irqReq.vector < 7'(cie_pkg::VEC_COUNT);
    assign takeAny  = trapTake | hwTake;
    assign swFlagsWr = regWrite && regAddr == cie_pkg::OFS_FLAGS;

    // entry is always pushed on the handler stack, which is selected as soon as entry starts except for trap numbers 32 and up
    assign pushAddr = handlerSp_reg - cie_pkg::WORD_STEP;

    // fixed vectors sit in the 0FFDCh table, the rest at a software base
    assign vecEntry = fixedVec_reg
                      ? cie_pkg::FIXVEC_FIRST + cie_pkg::VEC_STRIDE * 20'(vector_reg)
                      : vecBase_reg + cie_pkg::VEC_STRIDE * 20'(vector_reg);

    cie_addr_decode #(
        .ROM_BYTES (ROM_BYTES),
        .RAM_BYTES (RAM_BYTES)
    ) u_decode (
        .addr   (memAddr_reg),
        .region (memRegion)
    );

    always_comb begin
        state_next    = state_reg;
        memAddr_next  = memAddr_reg;
        memWdata_next = memWdata_reg;
        unique case (state_reg)
            cie_pkg::CIE_IDLE: begin
                if (takeAny) begin
                    state_next = cie_pkg::CIE_PUSH_HI;
                end
            end
            cie_pkg::CIE_PUSH_HI: begin
                // stack lives in internal RAM
                memAddr_next  = pushAddr;
                memWdata_next = {savedFlags_reg[15:4] & 12'h0F0 | {savedFlags_reg[14:12], 9'h000}
                                 | {4'h0, savedFlags_reg[7:0]}, savedPc_reg[19:16]} ;
                state_next    = cie_pkg::CIE_PUSH_LO;
            end
            cie_pkg::CIE_PUSH_LO: begin
                memAddr_next  = memAddr_reg - cie_pkg::WORD_STEP;
                memWdata_next = savedPc_reg[15:0];
                state_next    = cie_pkg::CIE_READ_LO;
            end
            cie_pkg::CIE_READ_LO: begin
                memAddr_next = vecEntry;
                state_next   = cie_pkg::CIE_READ_HI;
            end
            cie_pkg::CIE_READ_HI: begin
                memAddr_next = memAddr_reg + cie_pkg::WORD_STEP;
                state_next   = cie_pkg::CIE_DONE;
            end
            cie_pkg::CIE_DONE: begin
                state_next = cie_pkg::CIE_IDLE;
            end
            default: begin
                state_next = cie_pkg::CIE_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg    <= cie_pkg::CIE_IDLE;
            memAddr_reg  <= '0;
            memWdata_reg <= '0;
            memWrite_reg <= 1'b0;
            memRead_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            memAddr_reg  <= memAddr_next;
            memWdata_reg <= memWdata_next;
            memWrite_reg <= state_reg == cie_pkg::CIE_PUSH_HI
                            || state_reg == cie_pkg::CIE_PUSH_LO;
            memRead_reg  <= state_reg == cie_pkg::CIE_READ_LO
                            || state_reg == cie_pkg::CIE_READ_HI;
        end
    end

    // capture of the request being entered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            savedFlags_reg <= '0;
            savedPc_reg    <= '0;
            vector_reg     <= '0;
            fixedVec_reg   <= 1'b0;
        end else if (takeAny) begin
            savedFlags_reg <= flags_reg;
            savedPc_reg    <= returnPc;
            vector_reg     <= trapTake ? {1'b0, trapNum} : irqReq.vector;
            fixedVec_reg   <= hwTake && irqReq.vector < 7'(cie_pkg::FIXVEC_COUNT);
        end
    end

    // flag word; hardware entry overrides a same-cycle software write
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_reg <= cie_pkg::FLG_RESET;
        end else if (takeAny) begin
            flags_reg[cie_pkg::FLG_ENABLE] <= 1'b0;
            if (hwTake || !trapNum[cie_pkg::TRAP_HW_CUT]) begin
                flags_reg[cie_pkg::FLG_STACKSEL] <= 1'b0;
            end
            if (hwTake) begin
                flags_reg[cie_pkg::FLG_PRIO_MSB:cie_pkg::FLG_PRIO_LSB] <= irqReq.prio;
            end
        end else if (swFlagsWr) begin
            // reserved bits are not stored and read back as zero
            flags_reg <= {1'b0, regWdata[cie_pkg::FLG_PRIO_MSB:cie_pkg::FLG_PRIO_LSB],
                          4'h0, regWdata[cie_pkg::FLG_STACKSEL:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            handlerSp_reg <= cie_pkg::SP_RESET;
        end else if (state_reg == cie_pkg::CIE_PUSH_LO) begin
            handlerSp_reg <= memAddr_reg - cie_pkg::WORD_STEP;
        end else if (regWrite && regAddr == cie_pkg::OFS_HSP) begin
            handlerSp_reg <= regWdata[19:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            userSp_reg  <= cie_pkg::SP_RESET;
            vecBase_reg <= cie_pkg::VECBASE_RESET;
        end else begin
            if (regWrite && regAddr == cie_pkg::OFS_USERSP) begin
                userSp_reg <= regWdata[19:0];
            end
            if (regWrite && regAddr == cie_pkg::OFS_VECBASE) begin
                vecBase_reg <= regWdata[19:0];
            end
        end
    end

    // vector fetch and jump
    always_ff @(posedge core_clk) begin
        if (reset) begin
            vecLow_reg    <= '0;
            jumpValid_reg <= 1'b0;
            jumpPc_reg    <= '0;
            irqAck_reg    <= 1'b0;
            fetchHi_reg   <= 1'b0;
        end else begin
            irqAck_reg    <= takeAny;
            // memory answers a cycle after each strobe, so every word lands one state late
            fetchHi_reg   <= state_reg == cie_pkg::CIE_DONE;
            jumpValid_reg <= fetchHi_reg;
            if (state_reg == cie_pkg::CIE_DONE) begin
                vecLow_reg <= memRdata;
            end
            if (fetchHi_reg) begin
                jumpPc_reg <= {memRdata[3:0], vecLow_reg};
            end
        end
    end

    // sticky faults, write 1 to clear; a new fault in the same cycle wins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stackFault_reg <= 1'b0;
            accFault_reg   <= 1'b0;
        end else begin
            if (memWrite_reg && !memRegion.ram) begin
                stackFault_reg <= 1'b1;
            end else if (regWrite && regAddr == cie_pkg::OFS_STATUS
                         && regWdata[cie_pkg::ST_STACKFAULT]) begin
                stackFault_reg <= 1'b0;
            end
            // an entry access to peripheral or unmapped space sets the sticky access fault
            if ((memWrite_reg || memRead_reg) && (memRegion.periph || memRegion.unmapped)) begin
                accFault_reg <= 1'b1;
            end else if (regWrite && regAddr == cie_pkg::OFS_STATUS
                         && regWdata[cie_pkg::ST_ACCFAULT]) begin
                accFault_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            regRdata_reg <= '0;
        end else if (regRead) begin
            unique case (regAddr)
                cie_pkg::OFS_FLAGS:   regRdata_reg <= {16'h0000, flags_reg};
                cie_pkg::OFS_HSP:     regRdata_reg <= {12'h000, handlerSp_reg};
                cie_pkg::OFS_USERSP:  regRdata_reg <= {12'h000, userSp_reg};
                cie_pkg::OFS_VECBASE: regRdata_reg <= {12'h000, vecBase_reg};
                cie_pkg::OFS_STATUS:  regRdata_reg <= {17'h00000, vector_reg, 5'h00,
                                                       entryBusy, accFault_reg, stackFault_reg};
                default:              regRdata_reg <= '0;
            endcase
        end else begin
            regRdata_reg <= '0;
        end
    end

    assign regRdata  = regRdata_reg;
    assign memAddr   = memAddr_reg;
    assign memWrite  = memWrite_reg;
    assign memRead   = memRead_reg;
    assign memWdata  = memWdata_reg;
    assign irqAck    = irqAck_reg;
    assign ackVector = vector_reg;
    assign jumpValid = jumpValid_reg;
    assign jumpPc    = jumpPc_reg;
    assign entryBusy = state_reg != cie_pkg::CIE_IDLE;
endmodule // cie_core

// ---- common/cie_pkg.sv ----
// Function
// - maskable requests blocked while enable flag is 0, considered while 1.
// - accepting any interrupt clears the enable flag to 0.
// - stack flag 0 selects handler stack pointer, 1 selects user stack pointer; entry always pushes on the handler stack.
// - stack flag cleared on hardware interrupt or trap number 0 to 31.
// - three-bit processor priority level holds levels 0 to 7.
// - request accepted only if its priority exceeds the current level.
// - reserved flag bits should be written 0; reads return any value.
// - decode one-megabyte address space 00000h to FFFFFh.
// - program ROM ends at 0FFFFh and grows downward by ROM size.
// - fixed vector table occupies 0FFDCh to 0FFFFh.
// - data flash occupies 03000h to 03FFFh.
// - internal RAM starts at 00400h and grows upward by RAM size.
// - internal RAM holds data and the stack pushed on interrupt entry.
// - peripheral register area is 00000h-002FFh and 02C00h-02FFFh.
// - unassigned peripheral locations are reserved, never accessed.
// - 69 interrupt vectors, 7 selectable priority levels for maskable sources.
package cie_pkg;

    localparam int ADDR_W      = 20;
    localparam int DATA_W      = 16;
    localparam int VEC_W       = 7;
    localparam int VEC_COUNT   = 69;
    localparam int PRIO_W      = 3;
    localparam int TRAP_W      = 6;

    // memory map
    localparam logic [19:0] SPACE_LAST     = 20'hFFFFF;
    localparam logic [19:0] ROM_LAST       = 20'h0FFFF;
    localparam logic [19:0] ROM_TOP        = 20'h10000;
    localparam logic [19:0] FIXVEC_FIRST   = 20'h0FFDC;
    localparam logic [19:0] FLASH_FIRST    = 20'h03000;
    localparam logic [19:0] FLASH_LAST     = 20'h03FFF;
    localparam logic [19:0] RAM_FIRST      = 20'h00400;
    localparam logic [19:0] PERA_FIRST     = 20'h00000;
    localparam logic [19:0] PERA_LAST      = 20'h002FF;
    localparam logic [19:0] PERB_FIRST     = 20'h02C00;
    localparam logic [19:0] PERB_LAST      = 20'h02FFF;
    localparam int          ROM_BYTES_DEF  = 32768;
    localparam int          RAM_BYTES_DEF  = 2560;

    localparam int          FIXVEC_COUNT   = 9;
    localparam logic [2:0]  TRAP_HW_CUT    = 3'h5;   // trap numbers below 32 (bit 5 clear)
    localparam logic [19:0] VEC_STRIDE     = 20'h00004;
    localparam logic [19:0] WORD_STEP      = 20'h00002;

    // register port, word offsets
    localparam int          REG_AW         = 3;
    localparam logic [2:0]  OFS_FLAGS      = 3'h0;
    localparam logic [2:0]  OFS_HSP        = 3'h1;
    localparam logic [2:0]  OFS_USERSP     = 3'h2;
    localparam logic [2:0]  OFS_VECBASE    = 3'h3;
    localparam logic [2:0]  OFS_STATUS     = 3'h4;

    // flag word fields
    localparam int          FLG_COND_MSB   = 5;
    localparam int          FLG_ENABLE     = 6;
    localparam int          FLG_STACKSEL   = 7;
    localparam int          FLG_PRIO_LSB   = 12;
    localparam int          FLG_PRIO_MSB   = 14;
    localparam logic [15:0] FLG_RESET      = 16'h0000;
    localparam logic [19:0] SP_RESET       = 20'h00000;
    localparam logic [19:0] VECBASE_RESET  = 20'h00000;

    // status fields
    localparam int          ST_STACKFAULT  = 0;
    localparam int          ST_ACCFAULT    = 1;
    localparam int          ST_BUSY        = 2;
    localparam int          ST_VEC_LSB     = 8;

    typedef enum logic [2:0] {
        CIE_IDLE    = 3'h0,
        CIE_PUSH_HI = 3'h1,
        CIE_PUSH_LO = 3'h2,
        CIE_READ_LO = 3'h3,
        CIE_READ_HI = 3'h4,
        CIE_DONE    = 3'h5
    } cie_state_t;

    typedef struct packed {
        logic periph;
        logic ram;
        logic dataFlash;
        logic rom;
        logic vecTable;
        logic unmapped;
    } cie_region_t;

    typedef struct packed {
        logic             valid;
        logic [2:0]       prio;
        logic [6:0]       vector;
    } cie_irq_t;

endpackage

// ---- core/cie_addr_decode.sv ----
`timescale 1ns/10ps
module cie_addr_decode #(
    parameter int ROM_BYTES = cie_pkg::ROM_BYTES_DEF,
    parameter int RAM_BYTES = cie_pkg::RAM_BYTES_DEF
) (
    input  wire logic [19:0]         addr,
    output cie_pkg::cie_region_t     region
);
    localparam logic [19:0] ROM_FIRST = cie_pkg::ROM_TOP - 20'(ROM_BYTES);
    localparam logic [19:0] RAM_LAST  = cie_pkg::RAM_FIRST + 20'(RAM_BYTES) - 20'h00001;

    logic periphA;
    logic periphB;

    // the whole 20-bit space is decoded; anything not claimed is unmapped
    assign periphA = addr <= cie_pkg::PERA_LAST;
    assign periphB = addr >= cie_pkg::PERB_FIRST && addr <= cie_pkg::PERB_LAST;

    always_comb begin
        region           = '0;
        region.periph    = periphA | periphB;
        region.ram       = addr >= cie_pkg::RAM_FIRST && addr <= RAM_LAST;
        region.dataFlash = addr >= cie_pkg::FLASH_FIRST && addr <= cie_pkg::FLASH_LAST;
        region.rom       = addr >= ROM_FIRST && addr <= cie_pkg::ROM_LAST;
        region.vecTable  = addr >= cie_pkg::FIXVEC_FIRST && addr <= cie_pkg::ROM_LAST;
        region.unmapped  = !(region.periph | region.ram | region.dataFlash | region.rom);
    end
endmodule // cie_addr_decode

// ---- dv/cie_mem_model.sv ----
`timescale 1ns/10ps
module cie_mem_model (
    input  wire logic        core_clk,
    input  wire logic [19:0] memAddr,
    input  wire logic        memRead,
    output logic      [15:0] memRdata
);
    initial memRdata = 16'h0F0F;
    // word is a fixed function of the address so the bench can predict every fetch
    always @(posedge core_clk) begin
        if (memRead) begin
            memRdata <= memAddr[15:0] ^ 16'h5A5A;
        end else begin
            // toggles when idle so a stale word never passes for an answer
            memRdata <= ~memRdata;
        end
    end
endmodule // cie_mem_model

// ---- dv/cie_core_assertions.sv ----
`timescale 1ns/10ps
module cie_core_assertions #(
    parameter int ROM_BYTES = cie_pkg::ROM_BYTES_DEF,
    parameter int RAM_BYTES = cie_pkg::RAM_BYTES_DEF
) (
    input wire logic                 core_clk,
    input wire logic                 reset,
    input wire logic                 trapReq,
    input wire logic [19:0]          returnPc,
    input wire logic [19:0]          memAddr,
    input wire logic                 memWrite,
    input wire logic                 memRead,
    input wire logic [15:0]          memWdata,
    input wire logic [15:0]          memRdata,
    input wire logic                 irqAck,
    input wire logic                 jumpValid,
    input wire logic [19:0]          jumpPc,
    input wire logic                 entryBusy,
    input wire logic [19:0]          activeSp,
    input cie_pkg::cie_region_t      memRegion
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [15:0] rdOld_reg;
    logic [15:0] rdOlder_reg;
    always_ff @(posedge core_clk) begin
        rdOld_reg   <= memRdata;
        rdOlder_reg <= rdOld_reg;
    end
    sequence push_pair_s; memWrite ##1 memWrite; endsequence
    sequence fetch_pair_s; memRead ##1 memRead; endsequence
    a_trap_taken: assert property (trapReq && !entryBusy |=> irqAck)
        else $error("trap request not acknowledged");
    a_busy_ack: assert property (
        irqAck |-> entryBusy ##1 (!irqAck && entryBusy))
        else $error("acknowledge not a single pulse inside entry");
    a_entry_steps: assert property (
        irqAck |=> push_pair_s ##1 fetch_pair_s ##2 jumpValid)
        else $error("entry sequence out of order");
    a_push_addr: assert property (
        memWrite && $past(irqAck) |-> memAddr == activeSp - 20'h00002)
        else $error("first push not below stack pointer");
    a_push_low: assert property (
        memWrite && $past(memWrite) |->
        memAddr == $past(memAddr) - 20'h00002 && memWdata == 16'($past(returnPc, 3)))
        else $error("second push wrong");
    a_fetch_next: assert property (
        memRead && $past(memRead) |-> memAddr == $past(memAddr) + 20'h00002)
        else $error("vector high word address wrong");
    a_jump_pc: assert property (
        jumpValid |-> jumpPc == {rdOld_reg[3:0], rdOlder_reg})
        else $error("jump address not from vector words");
    // the vector table sits inside program memory, so it is left out of the one-hot set
    a_region_onehot: assert property (
        $onehot({memRegion.periph, memRegion.ram, memRegion.dataFlash, memRegion.rom,
                 memRegion.unmapped}))
        else $error("region decode not one-hot");
    a_vec_in_rom: assert property (memRegion.vecTable |-> memRegion.rom)
        else $error("vector table outside program memory");
    a_ram_decode: assert property (
        memAddr >= cie_pkg::RAM_FIRST
        && memAddr < cie_pkg::RAM_FIRST + RAM_BYTES |-> memRegion.ram)
        else $error("ram decode wrong");
    a_flash_decode: assert property (
        memAddr >= cie_pkg::FLASH_FIRST
        && memAddr <= cie_pkg::FLASH_LAST |-> memRegion.dataFlash)
        else $error("data flash decode wrong");
    a_periph_decode: assert property (
        memAddr <= cie_pkg::PERA_LAST || (memAddr >= cie_pkg::PERB_FIRST
        && memAddr <= cie_pkg::PERB_LAST) |-> memRegion.periph)
        else $error("peripheral decode wrong");
    a_vec_decode: assert property (
        memAddr >= cie_pkg::FIXVEC_FIRST
        && memAddr <= cie_pkg::ROM_LAST |-> memRegion.vecTable)
        else $error("vector table decode wrong");
    a_rom_decode: assert property (
        memAddr >= cie_pkg::ROM_TOP - ROM_BYTES
        && memAddr < cie_pkg::FIXVEC_FIRST |-> memRegion.rom)
        else $error("rom decode wrong");
endmodule // cie_core_assertions

bind cie_core cie_core_assertions #(.ROM_BYTES(ROM_BYTES), .RAM_BYTES(RAM_BYTES)) chk (
    .core_clk, .reset, .trapReq, .returnPc, .memAddr, .memWrite, .memRead, .memWdata,
    .memRdata, .irqAck, .jumpValid, .jumpPc, .entryBusy, .activeSp, .memRegion);

// ---- dv/cie_core_bench.sv ----
`timescale 1ns/10ps
module cie_core_bench;
    logic                 core_clk, reset, regWrite, regRead, trapReq, irqAck, jumpValid;
    logic                 entryBusy, memWrite, memRead;
    logic [2:0]           regAddr, lvl, p;
    logic [31:0]          regWdata, regRdata, rd;
    logic [5:0]           trapNum;
    logic [19:0]          returnPc, memAddr, jumpPc, activeSp, hsp, vb;
    logic [15:0]          memWdata, memRdata;
    logic [6:0]           ackVector, v;
    cie_pkg::cie_irq_t    irqReq;
    cie_pkg::cie_region_t memRegion;
    int                   num_errors, check_count, seed, i;

    cie_core dut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irqReq(irqReq),
        .trapReq(trapReq), .trapNum(trapNum), .returnPc(returnPc), .memAddr(memAddr),
        .memWrite(memWrite), .memRead(memRead), .memWdata(memWdata), .memRdata(memRdata),
        .irqAck(irqAck), .ackVector(ackVector), .jumpValid(jumpValid), .jumpPc(jumpPc),
        .entryBusy(entryBusy), .activeSp(activeSp), .memRegion(memRegion));
    cie_mem_model mem (.core_clk(core_clk), .memAddr(memAddr), .memRead(memRead),
        .memRdata(memRdata));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 rd = regRdata;
    endtask
    // reserved flag bits always written as zero
    task automatic set_flags(input logic en, input logic ss, input logic [2:0] l);
        reg_wr(cie_pkg::OFS_FLAGS, (32'(en) << cie_pkg::FLG_ENABLE) |
            (32'(ss) << cie_pkg::FLG_STACKSEL) | (32'(l) << cie_pkg::FLG_PRIO_LSB));
    endtask
    function automatic logic [19:0] vec_addr(input logic [6:0] n, input logic trap);
        if (!trap && n < 7'(cie_pkg::FIXVEC_COUNT))
            return cie_pkg::FIXVEC_FIRST + 20'(n) * cie_pkg::VEC_STRIDE;
        return vb + 20'(n) * cie_pkg::VEC_STRIDE;
    endfunction
    function automatic logic [19:0] exp_jump(input logic [19:0] e);
        logic [19:0] n;
        n = e + 20'h00002;
        return {n[3:0] ^ 4'hA, e[15:0] ^ 16'h5A5A};
    endfunction
    task automatic entry(input logic want, input logic trap, input logic [2:0] pr,
                         input logic [6:0] n);
        logic seen;
        logic done;
        seen = 1'b0;
        done = 1'b0;
        @(posedge core_clk);
        returnPc <= 20'($random(seed));
        irqReq   <= '{valid: !trap, prio: pr, vector: n};
        trapReq  <= trap;
        trapNum  <= n[5:0];
        for (int k = 0; k < 12 && !seen; k++) begin
            @(posedge core_clk);
            #1 seen = (irqAck === 1'b1);
        end
        chk_bit(seen, want);
        if (seen && !trap) chk_val(32'(ackVector), 32'(n));
        @(posedge core_clk);
        irqReq.valid <= 1'b0;
        trapReq      <= 1'b0;
        for (int k = 0; k < 12 && seen && !done; k++) begin
            @(posedge core_clk);
            #1 done = (jumpValid === 1'b1);
        end
        if (seen && !done) begin
            chk_bit(done, 1'b1);
            finish_test();
        end else if (seen) begin
            chk_val(32'(jumpPc), 32'(exp_jump(vec_addr(n, trap))));
            hsp = hsp - 20'h00004;
            // a high trap keeps the user stack, which the caller loads with the old handler value
            chk_val(32'(activeSp), 32'((trap && n[5]) ? hsp + 20'h00004 : hsp));
        end
    endtask

    initial begin
        seed = 91665;
        num_errors = 0;
        check_count = 0;
        reset = 1'b1;
        {regAddr, regWdata, regWrite, regRead, trapReq, trapNum} = '0;
        irqReq = '0;
        returnPc = 20'h0ABCD;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        for (i = 0; i < 6; i++) begin
            reg_rd(3'(i));
            chk_val(rd, 32'h0);
        end
        hsp = 20'h00A00;
        vb  = 20'h0C000;
        // stack in RAM, vectors in ROM then data flash: no reserved peripheral location is touched
        reg_wr(cie_pkg::OFS_HSP, 32'(hsp));
        reg_wr(cie_pkg::OFS_USERSP, 32'h00C00);
        reg_wr(cie_pkg::OFS_VECBASE, 32'(vb));
        set_flags(1'b0, 1'b1, 3'h0);
        #1 chk_val(32'(activeSp), 32'h00C00);
        set_flags(1'b0, 1'b0, 3'h0);
        #1 chk_val(32'(activeSp), 32'(hsp));
        set_flags(1'b0, 1'b1, 3'h0);
        entry(1'b0, 1'b0, 3'h5, 7'h07);
        set_flags(1'b1, 1'b1, 3'h0);
        entry(1'b1, 1'b0, 3'h5, 7'h07);
        reg_rd(cie_pkg::OFS_FLAGS);
        chk_bit(rd[cie_pkg::FLG_ENABLE], 1'b0);
        chk_bit(rd[cie_pkg::FLG_STACKSEL], 1'b0);
        chk_val(32'(rd[14:12]), 32'h5);
        for (i = 0; i < 14; i++) begin
            if (i == 7) begin
                vb = 20'h03000;
                reg_wr(cie_pkg::OFS_VECBASE, 32'(vb));
            end
            lvl = (i == 0) ? 3'h7 : 3'($random(seed));
            p = (i < 2) ? lvl : 3'($random(seed));
            v = 7'(($random(seed) & 32'h7F) % cie_pkg::VEC_COUNT);
            set_flags(1'b1, 1'b0, lvl);
            entry(p > lvl, 1'b0, p, v);
        end
        set_flags(1'b1, 1'b0, 3'h0);
        entry(1'b0, 1'b0, 3'h7, 7'h45);
        entry(1'b1, 1'b0, 3'h7, 7'h44);
        for (i = 31; i < 33; i++) begin
            set_flags(1'b0, 1'b1, 3'h0);
            reg_wr(cie_pkg::OFS_USERSP, 32'(hsp));
            entry(1'b1, 1'b1, 3'h0, 7'(i));
            reg_rd(cie_pkg::OFS_FLAGS);
            chk_bit(rd[cie_pkg::FLG_STACKSEL], i > 31);
            chk_bit(rd[cie_pkg::FLG_ENABLE], 1'b0);
        end
        // every push landed in RAM and no fetch touched reserved space; last vector was trap 32
        reg_rd(cie_pkg::OFS_STATUS);
        chk_val(rd, 32'h20 << cie_pkg::ST_VEC_LSB);
        finish_test();
    end
endmodule // cie_core_bench
